// ===== logic/bfd_decoder.sv
// byte/file-operation instruction decoder with alu and skip control
// assumes one instruction word per clk, operand byte valid with the word
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "bfd_defines.svh"

module bfd_decoder (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 instr_valid,
	input  wire logic [15:0]          instr_word,
	input  wire logic [7:0]           file_data,
	input  wire logic [7:0]           working_accumulator,
	input  wire logic                 carry_in,
	input  wire logic [3:0]           bank_select_reg,
	input  wire logic                 table_pointer_we,
	input  wire logic [20:0]          table_pointer_wdata,
	output logic      [20:0]          table_pointer,
	output logic      [11:0]          data_addr,
	output logic      [7:0]           result,
	output logic                      wr_acc,
	output logic                      wr_file,
	output logic                      wr_flags,
	output logic      [4:0]           flags_out,
	output logic      [11:0]          move_src,
	output logic      [11:0]          move_dst,
	output logic                      move_go,
	output logic      [20:0]          jump_target,
	output logic                      jump_go,
	output logic                      call_go,
	output logic                      call_fast,
	output logic      [2:0]           bit_pos,
	output logic      [7:0]           literal,
	output bfd_pkg::bfd_fmt_t         fmt,
	output logic                      nop_cycle,
	output logic                      skip_next
);
	import bfd_pkg::*;

	// ****************************************
	// field split
	// ****************************************
	logic [7:0]  f_addr;
	logic        f_dest;
	logic        f_acc;
	logic [2:0]  f_bit;
	logic [7:0]  f_lit;
	logic [11:0] f_long;
	logic        f_second;

	bfd_field_split u_split (
		.word       (instr_word),
		.file_addr  (f_addr),
		.dest_file  (f_dest),
		.acc_bsr    (f_acc),
		.bit_pos    (f_bit),
		.literal    (f_lit),
		.long_field (f_long),
		.is_second  (f_second)
	);

	// ****************************************
	// sequencing state
	// ****************************************
	bfd_state_t  state_r;
	bfd_state_t  state_nxt;
	logic [2:0]  pend_kind_r;   // 1 move, 2 jump, 4 call
	logic [11:0] pend_src_r;
	logic [7:0]  pend_lo_r;
	logic        pend_fast_r;
	logic        skip_two_r;    // skip covers a two-word instruction
	logic [20:0] table_pointer_r;

	// ****************************************
	// opcode decode
	// ****************************************
	bfd_alu_t alu_op;
	logic     is_byte_op;
	logic     is_cmp;
	logic     flags5;
	logic     flags2;
	logic     skip_z;
	logic     skip_nz;
	logic     is_file_to_file_move;
	logic     is_jump;
	logic     is_call;

	function automatic logic is_two_word(input logic [15:0] w);
		is_two_word = (w[15:12] == `BFD_OP4_FILE_TO_FILE_MOVE) ||
			(w[15:9] == `BFD_OP7_CALL) || (w[15:8] == `BFD_OP8_JUMP);
	endfunction : is_two_word

	always_comb begin
		alu_op     = BFD_ALU_NONE;
		is_byte_op = 1'b1;
		is_cmp     = 1'b0;
		flags5     = 1'b0;
		flags2     = 1'b0;
		skip_z     = 1'b0;
		skip_nz    = 1'b0;
		unique case (instr_word[15:10])
			`BFD_OP6_ADD: begin
				alu_op = BFD_ALU_ADD;
				flags5 = 1'b1;
			end
			`BFD_OP6_ADDC: begin
				alu_op = BFD_ALU_ADDC;
				flags5 = 1'b1;
			end
			`BFD_OP6_AND: begin
				alu_op = BFD_ALU_AND;
				flags2 = 1'b1;
			end
			`BFD_OP6_IOR: begin
				alu_op = BFD_ALU_IOR;
				flags2 = 1'b1;
			end
			`BFD_OP6_COM: begin
				alu_op = BFD_ALU_COM;
				flags2 = 1'b1;
			end
			`BFD_OP6_DEC: begin
				alu_op = BFD_ALU_DEC;
				flags5 = 1'b1;
			end
			`BFD_OP6_DECSZ: begin
				alu_op = BFD_ALU_DEC;
				skip_z = 1'b1;
			end
			`BFD_OP6_DECSNZ: begin
				alu_op  = BFD_ALU_DEC;
				skip_nz = 1'b1;
			end
			`BFD_OP6_INC: begin
				alu_op = BFD_ALU_INC;
				flags5 = 1'b1;
			end
			`BFD_OP6_INCSZ: begin
				alu_op = BFD_ALU_INC;
				skip_z = 1'b1;
			end
			`BFD_OP6_INCSNZ: begin
				alu_op  = BFD_ALU_INC;
				skip_nz = 1'b1;
			end
			default: begin
				is_byte_op = 1'b0;
				is_cmp     = (instr_word[15:9] == `BFD_OP7_CPEQ) ||
					(instr_word[15:9] == `BFD_OP7_CPGT) ||
					(instr_word[15:9] == `BFD_OP7_CPLT);
			end
		endcase
		is_file_to_file_move = (instr_word[15:12] == `BFD_OP4_FILE_TO_FILE_MOVE);
		is_jump  = (instr_word[15:8] == `BFD_OP8_JUMP);
		is_call  = (instr_word[15:9] == `BFD_OP7_CALL);
	end

	// format class for the datapath
	always_comb begin
		if (is_byte_op || is_cmp || is_file_to_file_move) begin
			fmt = BFD_FMT_BYTE;
		end else if (instr_word[15:12] >= `BFD_OP4_BITOP_LO &&
				instr_word[15:12] < `BFD_OP4_FILE_TO_FILE_MOVE) begin
			fmt = BFD_FMT_BIT;
		end else if (is_jump || is_call || instr_word[15:12] == 4'hD ||
				instr_word[15:12] == 4'hE || f_second) begin
			fmt = BFD_FMT_CTRL;
		end else begin
			fmt = BFD_FMT_LIT;
		end
	end

	// ****************************************
	// alu and flags (c, dc, z, ov, n as bits 0..4)
	// ****************************************
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] opb;
	logic       cin;
	logic [7:0] alu_res;
	logic [4:0] alu_flags;

	always_comb begin
		opb = working_accumulator;
		cin = 1'b0;
		unique case (alu_op)
			BFD_ALU_ADDC: cin = carry_in;
			BFD_ALU_DEC: opb = 8'hFF;
			BFD_ALU_INC: opb = 8'h00;
			default: ;
		endcase
		if (alu_op == BFD_ALU_INC) begin
			cin = 1'b1;
		end
		sum = {1'b0, file_data} + {1'b0, opb} + {8'h00, cin};
		nib = {1'b0, file_data[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
		unique case (alu_op)
			BFD_ALU_AND: alu_res = file_data & working_accumulator;
			BFD_ALU_IOR: alu_res = file_data | working_accumulator;
			BFD_ALU_COM: alu_res = ~file_data;
			default: alu_res = sum[7:0];
		endcase
		alu_flags[0] = sum[8];
		alu_flags[1] = nib[4];
		alu_flags[2] = (alu_res == 8'h00);
		alu_flags[3] = (file_data[7] == opb[7]) && (sum[7] != file_data[7]);
		alu_flags[4] = alu_res[7];
		if (flags2) begin
			alu_flags[1:0] = 2'b00;
			alu_flags[3]   = 1'b0;
		end
	end

	// compare-skip and increment/decrement skip conditions
	logic cond_skip;
	always_comb begin
		cond_skip = 1'b0;
		if (is_cmp) begin
			unique case (instr_word[15:9])
				`BFD_OP7_CPEQ: cond_skip = (file_data == working_accumulator);
				`BFD_OP7_CPGT: cond_skip = (file_data > working_accumulator);
				default: cond_skip = (file_data < working_accumulator);
			endcase
		end else if (skip_z) begin
			cond_skip = (alu_res == 8'h00);
		end else if (skip_nz) begin
			cond_skip = (alu_res != 8'h00);
		end
	end

	// ****************************************
	// issue: a word only acts in the exec state
	// ****************************************
	logic act;
	assign act = instr_valid && (state_r == BFD_ST_EXEC) && !f_second;

	always_comb begin
		state_nxt = state_r;
		if (instr_valid) begin
			unique case (state_r)
				BFD_ST_EXEC: begin
					if (act && (is_file_to_file_move || is_jump || is_call)) begin
						state_nxt = BFD_ST_SECOND;
					end else if (act && cond_skip) begin
						state_nxt = BFD_ST_SKIP;
					end
				end
				BFD_ST_SECOND: state_nxt = BFD_ST_EXEC;
				BFD_ST_SKIP: begin
					if (is_two_word(instr_word) && !skip_two_r) begin
						state_nxt = BFD_ST_SKIP;
					end else begin
						state_nxt = BFD_ST_EXEC;
					end
				end
				default: state_nxt = BFD_ST_EXEC;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= BFD_ST_EXEC;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_two_r <= 1'b0;
		end else if (instr_valid) begin
			skip_two_r <= (state_r == BFD_ST_SKIP) && !skip_two_r &&
				is_two_word(instr_word);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_kind_r <= 3'b000;
			pend_src_r  <= 12'h000;
			pend_lo_r   <= 8'h00;
			pend_fast_r <= 1'b0;
		end else if (act) begin
			pend_kind_r <= {is_call, is_jump, is_file_to_file_move};
			pend_src_r  <= f_long;
			pend_lo_r   <= f_lit;
			pend_fast_r <= instr_word[`BFD_POS_FAST];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			table_pointer_r <= `BFD_TABLE_POINTER_RST;
		end else if (table_pointer_we) begin
			table_pointer_r <= table_pointer_wdata;
		end
	end
	assign table_pointer = table_pointer_r;

	// ****************************************
	// registered outputs
	// ****************************************
	logic second_ok;
	assign second_ok = instr_valid && (state_r == BFD_ST_SECOND) && f_second;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_addr <= 12'h000;
			result    <= 8'h00;
			wr_acc    <= 1'b0;
			wr_file   <= 1'b0;
			wr_flags  <= 1'b0;
			flags_out <= 5'h00;
			bit_pos   <= 3'h0;
			literal   <= 8'h00;
		end else begin
			data_addr <= {f_acc ? bank_select_reg : `BFD_BSR_RST, f_addr};
			result    <= alu_res;
			wr_acc    <= act && is_byte_op && !f_dest;
			wr_file   <= act && is_byte_op && f_dest;
			wr_flags  <= act && (flags5 || flags2);
			flags_out <= alu_flags;
			bit_pos   <= f_bit;
			literal   <= f_lit;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			move_src    <= 12'h000;
			move_dst    <= 12'h000;
			move_go     <= 1'b0;
			jump_target <= 21'h000000;
			jump_go     <= 1'b0;
			call_go     <= 1'b0;
			call_fast   <= 1'b0;
			nop_cycle   <= 1'b0;
			skip_next   <= 1'b0;
		end else begin
			move_src    <= pend_src_r;
			move_dst    <= f_long;
			move_go     <= second_ok && pend_kind_r[0];
			jump_target <= {1'b0, f_long, pend_lo_r};
			jump_go     <= second_ok && pend_kind_r[1];
			call_go     <= second_ok && pend_kind_r[2];
			call_fast   <= pend_fast_r;
			nop_cycle   <= instr_valid && !act && !second_ok;
			skip_next   <= act && cond_skip;
		end
	end

endmodule : bfd_decoder

// ===== logic/bfd_defines.svh
// constants for the byte/file-operation instruction decoder
// assumes 16-bit instruction words and an 8-bit datapath
`ifndef BFD_DEFINES_SVH
`define BFD_DEFINES_SVH

// ****************************************
// opcode fields
// ****************************************
`define BFD_OP6_ADD      6'h09
`define BFD_OP6_ADDC     6'h08
`define BFD_OP6_AND      6'h05
`define BFD_OP6_IOR      6'h04
`define BFD_OP6_COM      6'h07
`define BFD_OP6_DEC      6'h01
`define BFD_OP6_DECSZ    6'h0B
`define BFD_OP6_DECSNZ   6'h13
`define BFD_OP6_INC      6'h0A
`define BFD_OP6_INCSZ    6'h0F
`define BFD_OP6_INCSNZ   6'h12
`define BFD_OP7_CPEQ     7'h31
`define BFD_OP7_CPGT     7'h32
`define BFD_OP7_CPLT     7'h30
`define BFD_OP4_FILE_TO_FILE_MOVE    4'hC
`define BFD_OP4_SECOND   4'hF
`define BFD_OP7_CALL     7'h76
`define BFD_OP8_JUMP     8'hEF
`define BFD_OP4_BITOP_LO 4'h8

// ****************************************
// field positions and reset values
// ****************************************
`define BFD_POS_DEST     9
`define BFD_POS_ACC      8
`define BFD_POS_FAST     8
`define BFD_TABLE_POINTER_RST   21'h000000
`define BFD_BSR_RST      4'h0

`endif

// ===== logic/bfd_field_split.sv
// field extraction of one instruction word
// assumes a 16-bit word from the fetch path
`timescale 1ns/1ps
`include "bfd_defines.svh"

module bfd_field_split (
	input  wire logic [15:0] word,
	output logic      [7:0]  file_addr,
	output logic             dest_file,
	output logic             acc_bsr,
	output logic      [2:0]  bit_pos,
	output logic      [7:0]  literal,
	output logic      [11:0] long_field,
	output logic             is_second
);
	import bfd_pkg::*;

	always_comb begin
		file_addr  = word[7:0];
		dest_file  = word[`BFD_POS_DEST];
		acc_bsr    = word[`BFD_POS_ACC];
		bit_pos    = word[11:9];
		literal    = word[7:0];
		long_field = word[11:0];
		is_second  = (word[15:12] == `BFD_OP4_SECOND);
	end

endmodule : bfd_field_split

// ===== logic/bfd_pkg.sv
// types for the instruction decoder
// assumes bfd_defines.svh is on the include path
package bfd_pkg;

	typedef enum logic [3:0] {
		BFD_FMT_BYTE = 4'h1,
		BFD_FMT_BIT  = 4'h2,
		BFD_FMT_LIT  = 4'h4,
		BFD_FMT_CTRL = 4'h8
	} bfd_fmt_t;

	typedef enum logic [3:0] {
		BFD_ALU_NONE = 4'h0,
		BFD_ALU_ADD  = 4'h1,
		BFD_ALU_ADDC = 4'h2,
		BFD_ALU_AND  = 4'h3,
		BFD_ALU_IOR  = 4'h4,
		BFD_ALU_COM  = 4'h5,
		BFD_ALU_DEC  = 4'h6,
		BFD_ALU_INC  = 4'h7
	} bfd_alu_t;

	typedef enum logic [2:0] {
		BFD_ST_EXEC   = 3'b001,
		BFD_ST_SECOND = 3'b010,
		BFD_ST_SKIP   = 3'b100
	} bfd_state_t;

endpackage : bfd_pkg

// ===== sim/bfd_file_model.sv
// file register datapath model: one bank of 256 bytes
// assumes operand read by the low byte of the fetched word
`timescale 1ns/1ps

// ****
// model
// ****
module bfd_file_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] instr_word,
	input  wire logic [11:0] data_addr,
	input  wire logic [7:0]  result,
	input  wire logic        wr_file,
	output logic      [7:0]  file_data
);
	logic [7:0] mem_r [256];
	assign file_data = mem_r[instr_word[7:0]];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 256; i++) mem_r[i] <= 8'(i);
		end else if (wr_file) begin
			mem_r[data_addr[7:0]] <= result;
		end
	end
endmodule : bfd_file_model

// ===== sim/bfd_monitor.sv
// port checker for the instruction decoder
// assumes it is bound to bfd_decoder
`timescale 1ns/1ps
`include "bfd_defines.svh"

// ****
// checker
// ****
module bfd_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [7:0]  file_data,
	input wire logic [7:0]  working_accumulator,
	input wire logic [3:0]  bank_select_reg,
	input wire logic        table_pointer_we,
	input wire logic [20:0] table_pointer_wdata,
	input wire logic [20:0] table_pointer,
	input wire logic [11:0] data_addr,
	input wire logic [7:0]  result,
	input wire logic        wr_acc,
	input wire logic        wr_file,
	input wire logic        wr_flags,
	input wire logic [11:0] move_src,
	input wire logic [11:0] move_dst,
	input wire logic        move_go,
	input wire logic        nop_cycle,
	input wire logic        skip_next
);
	logic skp_r;
	logic pair_r;
	logic two_w;
	logic ex;
	logic v;
	assign two_w = instr_word[15:12] == `BFD_OP4_FILE_TO_FILE_MOVE || instr_word[15:9] == `BFD_OP7_CALL
		|| instr_word[15:8] == `BFD_OP8_JUMP;
	// word would be executed, not skipped and not a second word
	assign ex = !skip_next && !skp_r && !pair_r;
	assign v = instr_valid && ex;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			skp_r <= 1'b0;
			pair_r <= 1'b0;
		end else if (instr_valid) begin
			skp_r <= (skip_next || skp_r) && two_w;
			pair_r <= ex && two_w;
		end else if (skip_next) begin
			skp_r <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_dest_route: assert property (v && instr_word[15:10] == `BFD_OP6_ADD |=>
		wr_file == $past(instr_word[9]) && wr_acc != $past(instr_word[9])) else $error("bad route");
	a_bank_addr: assert property (v && instr_word[15:10] == `BFD_OP6_ADD |=> data_addr ==
		{($past(instr_word[8]) ? $past(bank_select_reg) : 4'h0), $past(instr_word[7:0])})
		else $error("bad data address");
	a_add_sum: assert property (v && instr_word[15:10] == `BFD_OP6_ADD |=> wr_flags &&
		result == 8'($past(working_accumulator) + $past(file_data))) else $error("bad sum");
	a_cmp_flags: assert property (v && instr_word[15:9] == `BFD_OP7_CPEQ |=> !wr_flags &&
		skip_next == ($past(file_data) == $past(working_accumulator))) else $error("bad compare");
	a_skip_quiet: assert property (instr_valid && (skip_next || skp_r) |=> nop_cycle
		&& !wr_acc && !wr_file && !wr_flags && !move_go) else $error("skipped word wrote");
	a_move_pair: assert property (v && instr_word[15:12] == `BFD_OP4_FILE_TO_FILE_MOVE ##1 instr_valid &&
		instr_word[15:12] == `BFD_OP4_SECOND |=> move_go && move_src == $past(instr_word[11:0], 2)
		&& move_dst == $past(instr_word[11:0])) else $error("bad move");
	a_lone_second: assert property (v && instr_word[15:12] == `BFD_OP4_SECOND |=> nop_cycle
		&& !wr_acc && !wr_file && !wr_flags && !move_go) else $error("lone word acted");
	a_table_load: assert property (table_pointer_we |=> table_pointer == $past(table_pointer_wdata))
		else $error("bad table pointer");
	a_dec_skip: assert property (v && instr_word[15:10] == `BFD_OP6_DECSZ |=> !wr_flags &&
		skip_next == ($past(file_data) == 8'h01)) else $error("bad decrement skip");
endmodule : bfd_monitor

bind bfd_decoder bfd_monitor i_bfd_monitor (.clk, .rst_n, .instr_valid, .instr_word, .file_data,
	.working_accumulator, .bank_select_reg, .table_pointer_we, .table_pointer_wdata, .table_pointer, .data_addr,
	.result, .wr_acc, .wr_file, .wr_flags, .move_src, .move_dst, .move_go, .nop_cycle, .skip_next);

// ===== sim/test_byte_file_op_decoder.sv
// self-checking bench for the instruction decoder
// assumes bfd_file_model as operand source
`timescale 1ns/1ps
`include "bfd_defines.svh"

// ****
// bench
// ****
module test_byte_file_op_decoder;
	import bfd_pkg::*;
	logic clk = 0, rst_n = 0, instr_valid = 0, carry_in = 0, table_pointer_we = 0;
	logic [15:0] instr_word = 0;
	logic [7:0]  working_accumulator = 0, file_data, result, literal;
	logic [3:0]  bank_select_reg = 4'h5;
	logic [20:0] table_pointer_wdata = 0, table_pointer, jump_target;
	logic [11:0] data_addr, move_src, move_dst;
	logic        wr_acc, wr_file, wr_flags, move_go, jump_go, call_go, call_fast, nop_cycle;
	logic        skip_next;
	logic [4:0]  flags_out;
	logic [2:0]  bit_pos;
	bfd_fmt_t    fmt;
	int          mismatches = 0, n_checks = 0;
	bfd_decoder i_bfd_decoder (.clk, .rst_n, .instr_valid, .instr_word, .file_data,
		.working_accumulator, .carry_in, .bank_select_reg, .table_pointer_we, .table_pointer_wdata,
		.table_pointer, .data_addr, .result, .wr_acc, .wr_file, .wr_flags, .flags_out, .move_src,
		.move_dst, .move_go, .jump_target, .jump_go, .call_go, .call_fast, .bit_pos, .literal,
		.fmt, .nop_cycle, .skip_next);
	bfd_file_model i_bfd_file_model (.clk, .rst_n, .instr_word, .data_addr, .result, .wr_file,
		.file_data);
	always #25 clk = ~clk;
	task chk(input logic c, input string m);
		n_checks++;
		if (c !== 1'b1) begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task put(input logic [15:0] w);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= w;
	endtask : put
	task rest;
		@(posedge clk);
		instr_valid <= 1'b0;
		@(negedge clk);
	endtask : rest
	task alu(input logic [15:0] w, input logic [7:0] a, input logic c, input logic [7:0] r,
		input logic [4:0] f);
		put(w);
		working_accumulator <= a;
		carry_in <= c;
		rest;
		chk(result === r && flags_out === f && wr_flags === 1'b1, "alu result");
		chk(wr_file === w[9] && wr_acc === !w[9], "destination");
	endtask : alu
	task skp(input logic [15:0] w, input logic [7:0] a, input logic s);
		put(w);
		working_accumulator <= a;
		rest;
		chk(skip_next === s && wr_flags === 1'b0, "skip decision");
		if (s) begin
			put(16'h0000);
			rest;
			chk(nop_cycle === 1'b1 && wr_acc === 1'b0, "skipped word");
		end
	endtask : skp
	task t_alu;
		alu({`BFD_OP6_ADD, 2'b00, 8'h01}, 8'h7F, 1'b0, 8'h80, 5'b11010);
		alu({`BFD_OP6_ADDC, 2'b01, 8'hFF}, 8'h01, 1'b1, 8'h01, 5'b00011);
		chk(data_addr === 12'h5FF, "bank address");
		alu({`BFD_OP6_AND, 2'b00, 8'h0F}, 8'hF0, 1'b0, 8'h00, 5'b00100);
		alu({`BFD_OP6_COM, 2'b10, 8'h80}, 8'h00, 1'b0, 8'h7F, 5'b00000);
		alu({`BFD_OP6_IOR, 2'b00, 8'h80}, 8'h00, 1'b0, 8'h7F, 5'b00000);
		alu({`BFD_OP6_DEC, 2'b00, 8'h00}, 8'h00, 1'b0, 8'hFF, 5'b10000);
		alu({`BFD_OP6_INC, 2'b00, 8'h7F}, 8'h00, 1'b0, 8'h80, 5'b11010);
		$display("test alu done");
	endtask : t_alu
	task t_skip;
		skp({`BFD_OP7_CPEQ, 1'b0, 8'h10}, 8'h10, 1'b1);
		skp({`BFD_OP7_CPGT, 1'b0, 8'h20}, 8'h05, 1'b1);
		skp({`BFD_OP7_CPLT, 1'b0, 8'h20}, 8'h05, 1'b0);
		skp({`BFD_OP6_DECSZ, 2'b00, 8'h01}, 8'h00, 1'b1);
		skp({`BFD_OP6_DECSNZ, 2'b00, 8'h01}, 8'h00, 1'b0);
		skp({`BFD_OP6_INCSZ, 2'b00, 8'hFF}, 8'h00, 1'b1);
		skp({`BFD_OP6_INCSNZ, 2'b00, 8'hFF}, 8'h00, 1'b0);
		put({`BFD_OP7_CPEQ, 1'b0, 8'h10});
		working_accumulator <= 8'h10;
		put(16'hC123);
		put(16'hF456);
		@(negedge clk);
		chk(nop_cycle === 1'b1, "skipped first word");
		rest;
		chk(nop_cycle === 1'b1 && move_go === 1'b0, "skipped second word");
		$display("test skip done");
	endtask : t_skip
	task t_pair;
		put(16'hC123);
		put(16'hF456);
		rest;
		chk(move_go === 1'b1 && move_src === 12'h123 && move_dst === 12'h456, "move");
		put(16'hC123);
		put(16'h0401);
		rest;
		chk(move_go === 1'b0, "move without second word");
		put(16'hEF34);
		put(16'hFABC);
		rest;
		chk(jump_go === 1'b1 && call_go === 1'b0 && jump_target === 21'h0ABC34, "jump");
		put(16'hED12);
		put(16'hF001);
		rest;
		chk(call_go === 1'b1 && jump_go === 1'b0 && call_fast === 1'b1, "call");
		chk(jump_target === 21'h000112, "call target");
		$display("test pair done");
	endtask : t_pair
	task t_misc;
		logic [15:0] lone [2];
		lone = '{16'hF0A5, 16'hFFFF};
		put(16'h9A33);
		@(negedge clk);
		chk(fmt === BFD_FMT_BIT, "bit class");
		rest;
		chk(bit_pos === 3'h5, "bit position");
		put(16'h0E5A);
		@(negedge clk);
		chk(fmt === BFD_FMT_LIT, "literal class");
		rest;
		chk(literal === 8'h5A, "literal");
		foreach (lone[i]) begin
			put(lone[i]);
			@(negedge clk);
			chk(fmt === BFD_FMT_CTRL, "second word class");
			rest;
			chk(nop_cycle === 1'b1 && wr_acc === 1'b0 && wr_file === 1'b0, "lone word");
		end
		@(posedge clk);
		table_pointer_we <= 1'b1;
		table_pointer_wdata <= 21'h1ABCDE;
		@(posedge clk);
		table_pointer_we <= 1'b0;
		@(negedge clk);
		chk(table_pointer === 21'h1ABCDE, "table pointer");
		$display("test misc done");
	endtask : t_misc
	task results;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	initial begin
		#100000;
		mismatches++;
		results;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		chk(table_pointer === 21'h0, "table pointer reset");
		t_alu;
		t_skip;
		t_pair;
		t_misc;
		results;
	end
endmodule : test_byte_file_op_decoder
